/* File: core/skw_key_wake.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - second break byte compared with its register
// - set 2 third break byte compared
// - zero compare register matches any byte
// - battery reset loads set 2 power codes
// - two-bit field selects scan code format
// - set1 break sets top bit; set2 F0 prefix
// - match raises wake, power event, or both
// - release 00 withdraws event after half second
// - release 01 withdraws on other key
// - release 10 withdraws on break code
// - first make byte compared with first byte
// - lock bit makes compare and control registers read-only
// - lock clears on all resets; other control bits kept through bus reset
module skw_key_wake
  import skw_pkg::*;
#(
  parameter int unsigned PB_PULSE = PB_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic batteryReset,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scanValid,
  input wire logic [7:0] scanByte,
  input wire logic wakeEnable,
  input wire logic powerButtonEnable,
  output logic specificKeyWake,
  output logic keyboardPowerButtonEvent,
  output logic irq
);
  skw_match_if mif();

  logic [7:0] make1_q;
  logic [7:0] make2_q;
  logic [7:0] brk1_q;
  logic [7:0] brk2_q;
  logic [7:0] brk3_q;
  logic [7:0] ctrl_q;
  logic [IRQ_N-1:0] istat_q;
  logic [IRQ_N-1:0] imask_q;
  logic [31:0] rdData_d;
  logic req;
  logic wrEn;
  logic rdEn;
  logic locked;
  logic [7:0] wrByte;
  logic [31:0] pbCnt_q;
  logic pbSet;
  logic pbClr;
  skw_rel_t relMode;
  logic [IRQ_N-1:0] events;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrEn = req && wb_we_i && wb_sel_i[0];
  assign rdEn = req && !wb_we_i;
  assign locked = ctrl_q[CTL_LOCK];
  assign wrByte = wb_dat_i[7:0];
  assign relMode = skw_rel_t'(ctrl_q[CTL_REL_LO +: 2]);

  function automatic logic isAddr(input logic [ADDR_W-1:0] a, input int unsigned idx);
    isAddr = (a == idx[ADDR_W-1:0]);
  endfunction : isAddr

  // single-cycle ack, dropped the cycle after
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      wb_ack_o <= req;
      if (rdEn) begin
        wb_dat_o <= rdData_d;
      end
    end
  end

  always_comb begin
    rdData_d = 32'h0000_0000;
    if (isAddr(wb_adr_i, IDX_MAKE1)) rdData_d[7:0] = make1_q;
    if (isAddr(wb_adr_i, IDX_MAKE2)) rdData_d[7:0] = make2_q;
    if (isAddr(wb_adr_i, IDX_BRK1)) rdData_d[7:0] = brk1_q;
    if (isAddr(wb_adr_i, IDX_BRK2)) rdData_d[7:0] = brk2_q;
    if (isAddr(wb_adr_i, IDX_BRK3)) rdData_d[7:0] = brk3_q;
    if (isAddr(wb_adr_i, IDX_CTRL)) rdData_d[7:0] = ctrl_q;
    if (isAddr(wb_adr_i, IDX_ISTAT)) rdData_d[IRQ_N-1:0] = istat_q;
    if (isAddr(wb_adr_i, IDX_IMASK)) rdData_d[IRQ_N-1:0] = imask_q;
  end

  // compare registers live in the battery domain: only batteryReset restores them
  always_ff @(posedge ref_clk) begin
    if (batteryReset) begin
      make1_q <= RST_MAKE1;
      make2_q <= RST_MAKE2;
      brk1_q <= RST_BRK1;
      brk2_q <= RST_BRK2;
      brk3_q <= RST_BRK3;
    end else if (clkEn && wrEn && !locked) begin
      if (isAddr(wb_adr_i, IDX_MAKE1)) make1_q <= wrByte;
      if (isAddr(wb_adr_i, IDX_MAKE2)) make2_q <= wrByte;
      if (isAddr(wb_adr_i, IDX_BRK1)) brk1_q <= wrByte;
      if (isAddr(wb_adr_i, IDX_BRK2)) brk2_q <= wrByte;
      if (isAddr(wb_adr_i, IDX_BRK3)) brk3_q <= wrByte;
    end
  end

  // reserved bits are forced to their required values; software should match them
  always_ff @(posedge ref_clk) begin
    if (batteryReset) begin
      ctrl_q <= RST_CTRL;
    end else if (reset) begin
      ctrl_q[CTL_LOCK] <= 1'b0;
    end else if (clkEn && wrEn && !locked && isAddr(wb_adr_i, IDX_CTRL)) begin
      ctrl_q <= (wrByte & ~CTL_RSVD_MASK) | CTL_RSVD_VAL;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      imask_q <= '0;
    end else if (clkEn && wrEn && isAddr(wb_adr_i, IDX_IMASK)) begin
      imask_q <= wrByte[IRQ_N-1:0];
    end
  end

  assign mif.make1 = make1_q;
  assign mif.make2 = make2_q;
  assign mif.brk1 = brk1_q;
  assign mif.brk2 = brk2_q;
  assign mif.brk3 = brk3_q;
  assign mif.scanType = ctrl_q[CTL_TYPE_LO +: 2];
  assign mif.byteValid = scanValid;
  assign mif.byteData = scanByte;

  skw_decoder u_dec (
    .ref_clk(ref_clk),
    .reset(reset),
    .clkEn(clkEn),
    .m(mif)
  );

  assign pbSet = mif.makeHit && powerButtonEnable;
  always_comb begin
    pbClr = 1'b0;
    case (relMode)
      REL_TIMED: pbClr = (pbCnt_q == PB_PULSE - 1);
      REL_OTHER_KEY: pbClr = mif.otherKey;
      REL_BREAK: pbClr = mif.breakHit;
      default: pbClr = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      keyboardPowerButtonEvent <= 1'b0;
      specificKeyWake <= 1'b0;
      pbCnt_q <= 32'h0000_0000;
    end else if (clkEn) begin
      specificKeyWake <= mif.makeHit && wakeEnable;
      if (pbSet) begin
        keyboardPowerButtonEvent <= 1'b1;
        pbCnt_q <= 32'h0000_0000;
      end else if (keyboardPowerButtonEvent) begin
        if (pbClr) begin
          keyboardPowerButtonEvent <= 1'b0;
        end
        pbCnt_q <= pbCnt_q + 32'h0000_0001;
      end
    end
  end

  assign events[IRQ_WAKE] = specificKeyWake;
  assign events[IRQ_PB_SET] = pbSet;
  assign events[IRQ_PB_CLR] = keyboardPowerButtonEvent && pbClr && !pbSet;

  // read clears, but an event in the same cycle stays set
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      istat_q <= '0;
    end else if (clkEn) begin
      if (rdEn && isAddr(wb_adr_i, IDX_ISTAT)) begin
        istat_q <= events;
      end else begin
        istat_q <= istat_q | events;
      end
    end
  end

  assign irq = |(istat_q & imask_q);
endmodule : skw_key_wake

/* File: core/skw_pkg.sv */
package skw_pkg;
  // register indices: one bus word per register, not byte addresses
  localparam int unsigned IDX_MAKE1 = 32'h5F;
  localparam int unsigned IDX_MAKE2 = 32'h60;
  localparam int unsigned IDX_BRK1 = 32'h61;
  localparam int unsigned IDX_BRK2 = 32'h62;
  localparam int unsigned IDX_BRK3 = 32'h63;
  localparam int unsigned IDX_CTRL = 32'h64;
  localparam int unsigned IDX_ISTAT = 32'h70;
  localparam int unsigned IDX_IMASK = 32'h71;
  localparam int unsigned ADDR_W = 10;

  localparam logic [7:0] RST_MAKE1 = 8'hE0;
  localparam logic [7:0] RST_MAKE2 = 8'h37;
  localparam logic [7:0] RST_BRK1 = 8'hE0;
  localparam logic [7:0] RST_BRK2 = 8'hF0;
  localparam logic [7:0] RST_BRK3 = 8'h37;
  localparam logic [7:0] RST_CTRL = 8'h6C;
  localparam logic [7:0] WILDCARD = 8'h00;
  localparam logic [7:0] SET2_BREAK_PREFIX = 8'hF0;
  localparam logic [7:0] SET1_BREAK_BIT = 8'h80;

  // control fields
  localparam int unsigned CTL_TYPE_LO = 2;
  localparam int unsigned CTL_REL_LO = 4;
  localparam int unsigned CTL_LOCK = 7;
  localparam logic [7:0] CTL_RSVD_MASK = 8'h43;
  localparam logic [7:0] CTL_RSVD_VAL = 8'h40;

  typedef enum logic [1:0] {
    SC_SET1_SINGLE = 2'h0,
    SC_SET1_MULTI = 2'h1,
    SC_SET2_SINGLE = 2'h2,
    SC_SET2_MULTI = 2'h3
  } skw_scan_t;

  typedef enum logic [1:0] {
    REL_TIMED = 2'h0,
    REL_OTHER_KEY = 2'h1,
    REL_BREAK = 2'h2,
    REL_RSVD = 2'h3
  } skw_rel_t;

  // interrupt status bits
  localparam int unsigned IRQ_WAKE = 0;
  localparam int unsigned IRQ_PB_SET = 1;
  localparam int unsigned IRQ_PB_CLR = 2;
  localparam int unsigned IRQ_N = 3;

  localparam real PB_PULSE_S = 0.5;
  localparam real CLK_HZ = 125.0e6;
  localparam int unsigned PB_PULSE_CYC = int'($floor(PB_PULSE_S * CLK_HZ));
endpackage : skw_pkg

/* File: core/skw_match_if.sv */
`timescale 1ns/1ps
interface skw_match_if;
  logic [7:0] make1;
  logic [7:0] make2;
  logic [7:0] brk1;
  logic [7:0] brk2;
  logic [7:0] brk3;
  logic [1:0] scanType;
  logic byteValid;
  logic [7:0] byteData;
  logic makeHit;
  logic breakHit;
  logic otherKey;
  modport host (output make1, make2, brk1, brk2, brk3, scanType, byteValid, byteData,
    input makeHit, breakHit, otherKey);
  modport dec (input make1, make2, brk1, brk2, brk3, scanType, byteValid, byteData,
    output makeHit, breakHit, otherKey);
endinterface : skw_match_if

/* File: core/skw_decoder.sv */
`timescale 1ns/1ps
module skw_decoder
  import skw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  skw_match_if.dec m
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MK = 4'b0010,
    ST_BK = 4'b0100,
    ST_BK2 = 4'b1000
  } skw_dst_t;

  skw_dst_t state_q;
  logic [7:0] set1Brk;
  logic multi;
  logic set2;

  function automatic logic hit(input logic [7:0] ref_b, input logic [7:0] rx);
    hit = (ref_b == WILDCARD) || (ref_b == rx);
  endfunction : hit

  assign set1Brk = m.make2 | SET1_BREAK_BIT;
  assign multi = m.scanType[0];
  assign set2 = m.scanType[1];

  // one sequence tracker covers make and break; mismatch restarts from first byte
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      m.makeHit <= 1'b0;
      m.breakHit <= 1'b0;
      m.otherKey <= 1'b0;
    end else if (clkEn) begin
      m.makeHit <= 1'b0;
      m.breakHit <= 1'b0;
      m.otherKey <= 1'b0;
      if (m.byteValid) begin
        case (state_q)
          ST_IDLE: begin
            if (multi) begin
              if (hit(m.make1, m.byteData) || hit(m.brk1, m.byteData)) begin
                state_q <= ST_BK;
              end else begin
                m.otherKey <= 1'b1;
              end
            end else if (!set2 && hit(m.make1, m.byteData)) begin
              m.makeHit <= 1'b1;
            end else if (!set2 && hit(m.make1 | SET1_BREAK_BIT, m.byteData)) begin
              m.breakHit <= 1'b1;
            end else if (set2 && m.byteData == SET2_BREAK_PREFIX) begin
              state_q <= ST_BK2;
            end else if (set2 && hit(m.make1, m.byteData)) begin
              m.makeHit <= 1'b1;
            end else begin
              m.otherKey <= 1'b1;
            end
          end
          ST_BK: begin
            // after first byte: make second, set1 break, or set2 break prefix
            state_q <= ST_IDLE;
            if (hit(m.make2, m.byteData)) begin
              m.makeHit <= 1'b1;
            end else if (!set2 && hit(set1Brk, m.byteData)) begin
              m.breakHit <= 1'b1;
            end else if (set2 && hit(m.brk2, m.byteData)) begin
              state_q <= ST_MK;
            end else if (!set2 && hit(m.brk2, m.byteData)) begin
              m.breakHit <= 1'b1;
            end else begin
              m.otherKey <= 1'b1;
            end
          end
          ST_MK: begin
            state_q <= ST_IDLE;
            if (hit(m.brk3, m.byteData)) begin
              m.breakHit <= 1'b1;
            end else begin
              m.otherKey <= 1'b1;
            end
          end
          ST_BK2: begin
            state_q <= ST_IDLE;
            if (hit(m.make1, m.byteData)) begin
              m.breakHit <= 1'b1;
            end else begin
              m.otherKey <= 1'b1;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : skw_decoder

/* File: test/skw_key_wake_monitor.sv */
`timescale 1ns/1ps
module skw_key_wake_monitor
  import skw_pkg::*;
#(
  parameter int unsigned PB_PULSE = PB_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scanValid,
  input wire logic wakeEnable,
  input wire logic powerButtonEnable,
  input wire logic specificKeyWake,
  input wire logic keyboardPowerButtonEvent,
  input wire logic irq
);
  logic [31:0] hiCnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hiCnt_q <= 32'h0;
    end else if (clkEn) begin
      hiCnt_q <= keyboardPowerButtonEvent ? hiCnt_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset || !clkEn);
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  wake_cause_a: assert property (specificKeyWake |-> $past(scanValid, 2) && wakeEnable)
    else $error("wake pulse without a key byte or enable");
  pb_cause_a: assert property ($rose(keyboardPowerButtonEvent) |->
    $past(scanValid, 2) && powerButtonEnable) else $error("power event without cause");
  // a bus reset may also withdraw the event
  pb_length_a: assert property ($fell(keyboardPowerButtonEvent) |->
    hiCnt_q == PB_PULSE || $past(scanValid, 2) || $past(reset))
    else $error("power event dropped early");
  reset_quiet_a: assert property ($fell(reset) |->
    !keyboardPowerButtonEvent && !specificKeyWake && !irq) else $error("outputs not cleared");
  wake_once_a: assert property (specificKeyWake |=> !specificKeyWake)
    else $error("wake pulse longer than one cycle");
endmodule : skw_key_wake_monitor

bind skw_key_wake skw_key_wake_monitor #(.PB_PULSE(PB_PULSE)) mon (.ref_clk(ref_clk),
  .reset(reset), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scanValid(scanValid),
  .wakeEnable(wakeEnable), .powerButtonEnable(powerButtonEnable),
  .specificKeyWake(specificKeyWake), .keyboardPowerButtonEvent(keyboardPowerButtonEvent),
  .irq(irq));

/* File: test/skw_kbd_model.sv */
`timescale 1ns/1ps
module skw_kbd_model (
  input wire logic ref_clk,
  output logic scanValid,
  output logic [7:0] scanByte
);
  initial begin
    scanValid = 1'b0;
    scanByte = 8'hA5;
  end
  // data goes stale when idle so a held byte never looks fresh
  task automatic sendByte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    scanValid <= 1'b1;
    scanByte <= b;
    @(posedge ref_clk);
    scanValid <= 1'b0;
    scanByte <= ~b;
  endtask : sendByte
endmodule : skw_kbd_model

/* File: test/skw_key_wake_tb_top.sv */
`timescale 1ns/1ps
module skw_key_wake_tb_top import skw_pkg::*;;
  localparam int unsigned PB = 20;
  logic ref_clk = 1'b0, reset = 1'b1, batteryReset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
  logic wbWe = 1'b0, wbAck, scanValid, wakeEnable = 1'b1, pbEnable = 1'b1, wake, pbEvent, irq;
  logic clkEn = 1'b1;
  logic [ADDR_W-1:0] wbAdr = '0;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  logic [7:0] scanByte;
  int miscompares = 0, numChecks = 0, cycles = 0, wakes = 0;
  always #4 ref_clk = ~ref_clk;
  skw_kbd_model kbd (.ref_clk(ref_clk), .scanValid(scanValid), .scanByte(scanByte));
  skw_key_wake #(.PB_PULSE(PB)) DUT (.ref_clk(ref_clk), .reset(reset),
    .batteryReset(batteryReset), .clkEn(clkEn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .scanValid(scanValid), .scanByte(scanByte), .wakeEnable(wakeEnable),
    .powerButtonEnable(pbEnable), .specificKeyWake(wake),
    .keyboardPowerButtonEvent(pbEvent), .irq(irq));
  task automatic conclude;
    if (miscompares == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  always @(posedge ref_clk) begin
    if (wake === 1'b1) wakes++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    numChecks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wb(input logic we, input int unsigned a, input logic [7:0] d);
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a[ADDR_W-1:0];
    wbDatI <= {24'h000000, d};
    @(posedge ref_clk);
    while (wbAck !== 1'b1) @(posedge ref_clk);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb
  task automatic rdChk(input string n, input int unsigned a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(n, rd, {24'h000000, e});
  endtask : rdChk
  task automatic key(input logic [23:0] s, input int n);
    for (int i = n; i > 0; i--) kbd.sendByte(s[8*i-8 +: 8], i - 1);
    repeat (3) @(posedge ref_clk);
  endtask : key
  task automatic defaults;
    rdChk("brk2", IDX_BRK2, 8'hF0);
    rdChk("brk3", IDX_BRK3, 8'h37);
    rdChk("ctrl", IDX_CTRL, 8'h6C);
    rdChk("make1", IDX_MAKE1, 8'hE0);
  endtask : defaults
  task automatic typeRun(input logic [7:0] c, input logic [7:0] m1, input logic [23:0] mk,
      input int mn, input logic [23:0] bk, input int bn);
    wb(1'b1, IDX_CTRL, c);
    wb(1'b1, IDX_MAKE1, m1);
    wb(1'b1, IDX_MAKE2, 8'h37);
    check("typeIdle", pbEvent, 0);
    key(mk, mn);
    check("typeMake", pbEvent, 1);
    key(bk, bn);
    check("typeBreak", pbEvent, 0);
  endtask : typeRun
  task automatic pulse(input logic b);
    @(posedge ref_clk);
    reset <= 1'b1;
    batteryReset <= b;
    @(posedge ref_clk);
    reset <= 1'b0;
    batteryReset <= 1'b0;
  endtask : pulse
  initial begin
    int w;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    batteryReset <= 1'b0;
    defaults();
    rdChk("unmapped", 32'h3FF, 8'h00);
    key(24'h00E037, 2);
    check("pbSet", pbEvent, 1);
    check("wakeCnt", wakes, 1);
    key(24'hE0F038, 3);
    check("pbHold", pbEvent, 1);
    key(24'hE0F037, 3);
    check("pbBreak", pbEvent, 0);
    check("irqMasked", irq, 0);
    wb(1'b1, IDX_IMASK, 8'h01);
    @(posedge ref_clk);
    check("irqOn", irq, 1);
    rdChk("istat", IDX_ISTAT, 8'h07);
    @(posedge ref_clk);
    check("irqOff", irq, 0);
    wb(1'b1, IDX_CTRL, 8'h4C);
    key(24'h00E037, 2);
    check("timedSet", pbEvent, 1);
    // a low clock enable must hold the release count too
    clkEn <= 1'b0;
    repeat (PB) @(posedge ref_clk);
    check("frozen", pbEvent, 1);
    clkEn <= 1'b1;
    repeat (PB - 4) @(posedge ref_clk);
    check("timedHold", pbEvent, 1);
    repeat (4) @(posedge ref_clk);
    check("timedClr", pbEvent, 0);
    wb(1'b1, IDX_CTRL, 8'h5C);
    key(24'h00E037, 2);
    key(24'h00E037, 2);
    check("sameKey", pbEvent, 1);
    key(24'h00001C, 1);
    check("otherKey", pbEvent, 0);
    pbEnable <= 1'b0;
    w = wakes;
    key(24'h00E037, 2);
    check("noPbEvent", pbEvent, 0);
    check("wakeOnly", wakes, w + 1);
    pbEnable <= 1'b1;
    wb(1'b1, IDX_CTRL, 8'h6C);
    wb(1'b1, IDX_MAKE2, 8'h00);
    wakeEnable <= 1'b0;
    w = wakes;
    key(24'h00E055, 2);
    check("wildcard", pbEvent, 1);
    check("noWake", wakes, w);
    wakeEnable <= 1'b1;
    wb(1'b1, IDX_MAKE2, 8'h37);
    key(24'hE0F037, 3);
    check("wildBreak", pbEvent, 0);
    typeRun(8'h60, 8'h37, 24'h37, 1, 24'hB7, 1);
    typeRun(8'h64, 8'hE0, 24'hE037, 2, 24'hE0B7, 2);
    typeRun(8'h68, 8'h37, 24'h37, 1, 24'hF037, 2);
    wb(1'b1, IDX_CTRL, 8'hCC);
    wb(1'b1, IDX_BRK3, 8'h11);
    rdChk("lockedBrk3", IDX_BRK3, 8'h37);
    rdChk("lockedCtrl", IDX_CTRL, 8'hCC);
    pulse(1'b0);
    rdChk("ctrlKept", IDX_CTRL, 8'h4C);
    pulse(1'b1);
    defaults();
    conclude();
  end
endmodule : skw_key_wake_tb_top
